// File: core/ccaa_pkg.sv
// Package: offsets, fields, reset values and codes of the clock/attack bank
package ccaa_pkg;

  // Register offsets on the control port
  localparam logic [7:0] ADDR_RSVD_A   = 8'h64;
  localparam logic [7:0] ADDR_CORE_SRC = 8'h65;
  localparam logic [7:0] ADDR_CLK_GEN  = 8'h66;
  localparam logic [7:0] ADDR_ATTACK   = 8'h67;

  // Reset values
  localparam logic [7:0] RST_RSVD_A    = 8'h00;
  localparam logic       RST_CORE_SEL  = 1'h0;
  localparam logic [7:0] RST_CLK_GEN   = 8'h02;
  localparam logic [7:0] RST_ATTACK    = 8'h00;

  // Field positions
  localparam int unsigned CORE_SEL_BIT  = 0;
  localparam int unsigned DIVIN_MSB     = 7;
  localparam int unsigned DIVIN_LSB     = 6;
  localparam int unsigned PLLREF_MSB    = 5;
  localparam int unsigned PLLREF_LSB    = 4;
  localparam int unsigned NDIV_MSB      = 3;
  localparam int unsigned NDIV_LSB      = 0;
  localparam int unsigned ATK_SEL_BIT   = 7;
  localparam int unsigned ATK_BASE_MSB  = 6;
  localparam int unsigned ATK_BASE_LSB  = 5;
  localparam int unsigned ATK_MULT_MSB  = 4;
  localparam int unsigned ATK_MULT_LSB  = 2;

  // Input pin codes for the divider and PLL reference selects
  localparam logic [1:0] SRC_MCLK      = 2'h0;
  localparam logic [1:0] SRC_BCLK      = 2'h2;

  // Divider value codes that do not mean their own value
  localparam logic [3:0] N_CODE_16     = 4'h0;
  localparam logic [3:0] N_CODE_17     = 4'h1;
  localparam logic [4:0] N_VAL_16      = 5'h10;
  localparam logic [4:0] N_VAL_17      = 5'h11;

  // Baseline attack times in milliseconds
  localparam int unsigned ATK_MS_W     = 11;
  localparam logic [3:0] ATK_MS_0      = 4'h7;
  localparam logic [3:0] ATK_MS_1      = 4'h8;
  localparam logic [3:0] ATK_MS_2      = 4'hA;
  localparam logic [3:0] ATK_MS_3      = 4'hB;

  // Register access request from the control bus decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccaa_req_t;

  // Clock routing seen by the clock tree
  typedef struct packed {
    logic       core_sel;
    logic [1:0] div_in;
    logic [1:0] pll_ref;
    logic [4:0] pll_n;
  } ccaa_clk_cfg_t;

  // Divider code to divide ratio
  function automatic logic [4:0] ccaa_n_decode(input logic [3:0] code);
    if (code == N_CODE_16) begin
      return N_VAL_16;
    end else if (code == N_CODE_17) begin
      return N_VAL_17;
    end
    return {1'h0, code};
  endfunction : ccaa_n_decode

  // Baseline time shifted by the multiplier exponent
  function automatic logic [ATK_MS_W-1:0] ccaa_atk_ms(
      input logic [1:0] base, input logic [2:0] mult);
    logic [ATK_MS_W-1:0] ms;
    ms = '0;
    case (base)
      2'h0: ms = {7'h00, ATK_MS_0};
      2'h1: ms = {7'h00, ATK_MS_1};
      2'h2: ms = {7'h00, ATK_MS_2};
      default: ms = {7'h00, ATK_MS_3};
    endcase
    return ms << mult;
  endfunction : ccaa_atk_ms

endpackage : ccaa_pkg

// File: core/ccaa_regs.sv
// Clock source selection and left attack time register bank
// Operation
// - The slot at 0x64 is reserved and always reads as zero from reset on.
// - Bit 0 of 0x65 picks the core clock: 0 PLL divider, 1 plain divider.
// - Bits 7..1 at 0x65 are reserved, read-only and always read zero.
// - Bits 7..6 of 0x66 feed the plain divider: 00 master, 10 bit clock.
// - Bits 5..4 of 0x66 feed the PLL reference: 00 master, 10 bit clock.
// - Bits 3..0 of 0x66: PLL ratio, 0 means 16, 1 means 17, else itself.
// - Bit 7 of 0x67 takes the left attack time from here, not legacy.
// - Bits 6..5 at 0x67 give a baseline attack of 7, 8, 10 or 11 ms.
// - Bits 4..2 of 0x67 scale the baseline by two to the code's power.
`timescale 1ns/1ns

module ccaa_regs
  import ccaa_pkg::*;
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_rstn,
  input  ccaa_req_t               i_req,
  input  wire logic [ATK_MS_W-1:0] i_legacy_attack_ms,
  output logic                    o_rd_valid,
  output logic [7:0]              o_rd_data,
  output ccaa_clk_cfg_t           o_clk_cfg,
  output logic                    o_div_in_bclk,
  output logic                    o_pll_ref_bclk,
  output logic                    o_attack_override,
  output logic [ATK_MS_W-1:0]     o_left_attack_ms
);

  // Stored state
  logic                core_sel_r;
  logic                core_sel_nxt;
  logic [7:0]          clk_gen_r;
  logic [7:0]          clk_gen_nxt;
  logic [7:0]          attack_r;
  logic [7:0]          attack_nxt;
  logic                rd_valid_r;
  logic [7:0]          rd_data_r;
  logic [7:0]          rd_data_nxt;
  ccaa_clk_cfg_t       clk_cfg_r;
  ccaa_clk_cfg_t       clk_cfg_nxt;
  logic                div_in_bclk_r;
  logic                pll_ref_bclk_r;
  logic                attack_override_r;
  logic [ATK_MS_W-1:0] left_attack_ms_r;
  logic [ATK_MS_W-1:0] left_attack_ms_nxt;
  logic [ATK_MS_W-1:0] local_attack_ms;

  // Address decode of the request
  wire hit_rsvd_a   = (i_req.addr == ADDR_RSVD_A);
  wire hit_core_src = (i_req.addr == ADDR_CORE_SRC);
  wire hit_clk_gen  = (i_req.addr == ADDR_CLK_GEN);
  wire hit_attack   = (i_req.addr == ADDR_ATTACK);
  wire wr_core_src  = i_req.wr && hit_core_src;
  wire wr_clk_gen   = i_req.wr && hit_clk_gen;
  wire wr_attack    = i_req.wr && hit_attack;
  // Any mapped offset; only the checks below read it
  wire hit_any      = hit_rsvd_a || hit_core_src || hit_clk_gen || hit_attack;

  // Only bit 0 of the source register has storage behind it
  assign core_sel_nxt = wr_core_src ? i_req.wdata[CORE_SEL_BIT]
                                    : core_sel_r;
  // Reserved pin codes are stored as written; the host keeps them out
  // Limitation: such a code reaches the clock tree unfiltered
  assign clk_gen_nxt  = wr_clk_gen ? i_req.wdata
                                   : clk_gen_r;
  // Low two bits are kept as written, software leaves them zero
  assign attack_nxt   = wr_attack ? i_req.wdata : attack_r;

  // Read mux; reserved slot and unmapped offsets return zero
  assign rd_data_nxt =
      hit_rsvd_a   ? RST_RSVD_A :
      hit_core_src ? {7'h00, core_sel_r} :
      hit_clk_gen  ? clk_gen_r :
      hit_attack   ? attack_r : 8'h00;

  // Clock routing follows the next stored value, so it moves with the write
  assign clk_cfg_nxt = '{
      core_sel: core_sel_nxt,
      div_in:   clk_gen_nxt[DIVIN_MSB:DIVIN_LSB],
      pll_ref:  clk_gen_nxt[PLLREF_MSB:PLLREF_LSB],
      pll_n:    ccaa_n_decode(clk_gen_nxt[NDIV_MSB:NDIV_LSB])};

  // Attack time: baseline scaled by the multiplier, or the legacy value
  assign local_attack_ms = ccaa_atk_ms(attack_nxt[ATK_BASE_MSB:ATK_BASE_LSB],
      attack_nxt[ATK_MULT_MSB:ATK_MULT_LSB]);
  // Legacy value is taken every edge, so it needs no local copy
  assign left_attack_ms_nxt = attack_nxt[ATK_SEL_BIT] ?
      local_attack_ms : i_legacy_attack_ms;

  // Configuration registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      core_sel_r <= RST_CORE_SEL;
      clk_gen_r  <= RST_CLK_GEN;
      attack_r   <= RST_ATTACK;
    end else begin
      core_sel_r <= core_sel_nxt;
      clk_gen_r  <= clk_gen_nxt;
      attack_r   <= attack_nxt;
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rd_valid_r <= 1'h0;
      rd_data_r  <= 8'h00;
    end else begin
      rd_valid_r <= i_req.rd;
      rd_data_r  <= i_req.rd ? rd_data_nxt : 8'h00;
    end
  end

  // Registered copies for the clock tree and the gain control
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      clk_cfg_r         <= '{core_sel: RST_CORE_SEL,
                             div_in:   RST_CLK_GEN[DIVIN_MSB:DIVIN_LSB],
                             pll_ref:  RST_CLK_GEN[PLLREF_MSB:PLLREF_LSB],
                             pll_n:    ccaa_n_decode(RST_CLK_GEN[3:0])};
      div_in_bclk_r     <= 1'h0;
      pll_ref_bclk_r    <= 1'h0;
      attack_override_r <= 1'h0;
      left_attack_ms_r  <= '0;
    end else begin
      clk_cfg_r         <= clk_cfg_nxt;
      div_in_bclk_r     <= (clk_cfg_nxt.div_in == SRC_BCLK);
      pll_ref_bclk_r    <= (clk_cfg_nxt.pll_ref == SRC_BCLK);
      attack_override_r <= attack_nxt[ATK_SEL_BIT];
      left_attack_ms_r  <= left_attack_ms_nxt;
    end
  end

  // Outputs straight from flops
  assign o_rd_valid        = rd_valid_r;
  assign o_rd_data         = rd_data_r;
  assign o_clk_cfg         = clk_cfg_r;
  assign o_div_in_bclk     = div_in_bclk_r;
  assign o_pll_ref_bclk    = pll_ref_bclk_r;
  assign o_attack_override = attack_override_r;
  assign o_left_attack_ms  = left_attack_ms_r;

  // Checks; the legacy input is sampled, not trusted stable
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // Reserved slot reads zero even right after a write to it
  AST_RSVD_A_ZERO: assert property (
    (i_req.rd && hit_rsvd_a) |=> (o_rd_valid && o_rd_data == 8'h00))
    else $error("reserved slot did not read zero");

  // Core select follows the written bit on the next edge
  AST_CORE_SEL: assert property (
    wr_core_src |=> (o_clk_cfg.core_sel == $past(i_req.wdata[0])))
    else $error("core clock select does not follow write");

  // Upper bits of source register always read zero
  AST_CORE_RSVD: assert property (
    (i_req.rd && hit_core_src) |=> (o_rd_data[7:1] == 7'h00))
    else $error("reserved source bits read nonzero");

  // Divider input code and its decoded pin agree with the write
  AST_DIV_IN: assert property (
    wr_clk_gen |=> (o_clk_cfg.div_in == $past(i_req.wdata[7:6]) &&
                    o_div_in_bclk == (o_clk_cfg.div_in == SRC_BCLK)))
    else $error("divider input select mismatch");

  // PLL reference code and its decoded pin agree with the write
  AST_PLL_REF: assert property (
    wr_clk_gen |=> (o_clk_cfg.pll_ref == $past(i_req.wdata[5:4]) &&
                    o_pll_ref_bclk == (o_clk_cfg.pll_ref == SRC_BCLK)))
    else $error("pll reference select mismatch");

  // Code 0 gives 16, two cycles on the ratio is in range
  AST_PLL_N: assert property (
    (wr_clk_gen && i_req.wdata[3:0] == N_CODE_16) |=>
      (o_clk_cfg.pll_n == N_VAL_16) ##1
      (o_clk_cfg.pll_n >= 5'h02 && o_clk_cfg.pll_n <= N_VAL_17))
    else $error("pll divide ratio decode wrong");

  // Without override the legacy time passes through
  AST_ATK_LEGACY: assert property (
    !attack_nxt[ATK_SEL_BIT] |=>
      (!o_attack_override && o_left_attack_ms == $past(i_legacy_attack_ms)))
    else $error("legacy attack time not selected");

  // Override with baseline code 0 and multiplier 0 gives 7 ms
  AST_ATK_BASE: assert property (
    (wr_attack && i_req.wdata[7:2] == 6'h20) |=>
      (o_attack_override && o_left_attack_ms == 11'h007))
    else $error("baseline attack time wrong");

  // Largest setting gives 11 ms times 128
  AST_ATK_MULT: assert property (
    (wr_attack && i_req.wdata[7:2] == 6'h3F) |=>
      (o_left_attack_ms == 11'h580))
    else $error("attack multiplier wrong");

  // A write to the reserved slot disturbs no stored state
  AST_RSVD_HOLD: assert property (
    (i_req.wr && hit_rsvd_a) |=>
      ($stable(core_sel_r) && $stable(clk_gen_r) && $stable(attack_r)))
    else $error("reserved write changed stored state");

  // Read answer strobe, idle level and read-back paths
  // Answer strobe follows every read by exactly one edge
  AST_RD_PULSE: assert property (
    i_req.rd |=>
      o_rd_valid)
    else $error("read answer strobe missing");

  // Between answers the port shows zero, so idle data can be merged
  AST_RD_IDLE: assert property (
    !i_req.rd |=>
      (!o_rd_valid && o_rd_data == 8'h00))
    else $error("read port not idle after no read");

  // Unmapped offsets answer with zero
  AST_RD_UNMAPPED: assert property (
    (i_req.rd && !hit_any) |=>
      (o_rd_data == 8'h00))
    else $error("unmapped offset read nonzero");

  // Source bit reads back the value held before the read edge
  AST_RD_CORE_BIT: assert property (
    (i_req.rd && hit_core_src) |=>
      (o_rd_data[0] == $past(core_sel_r)))
    else $error("core select read-back wrong");

  // Clock generation byte reads back as stored, reserved codes too
  AST_RD_CLK_GEN: assert property (
    (i_req.rd && hit_clk_gen) |=>
      (o_rd_data == $past(clk_gen_r)))
    else $error("clock generation read-back wrong");

  // Attack byte reads back as stored, low reserved bits included
  AST_RD_ATTACK: assert property (
    (i_req.rd && hit_attack) |=>
      (o_rd_data == $past(attack_r)))
    else $error("attack register read-back wrong");

  // Routing outputs only move on a write to their own register
  // Core select holds while its register is not written
  AST_CORE_HOLD: assert property (
    !wr_core_src |=>
      $stable(o_clk_cfg.core_sel))
    else $error("core clock select moved without write");

  // Clock generation fields hold while the register is not written
  AST_CLK_GEN_HOLD: assert property (
    !wr_clk_gen |=>
      ($stable(o_clk_cfg.div_in) && $stable(o_clk_cfg.pll_ref) &&
       $stable(o_clk_cfg.pll_n)))
    else $error("clock generation fields moved without write");

  // Code 1 gives a ratio of 17
  AST_PLL_N_17: assert property (
    (wr_clk_gen && i_req.wdata[3:0] == N_CODE_17) |=>
      (o_clk_cfg.pll_n == N_VAL_17))
    else $error("pll ratio for code one wrong");

  // Codes 2 to 15 give their own value
  AST_PLL_N_SELF: assert property (
    (wr_clk_gen && i_req.wdata[3:0] > N_CODE_17) |=>
      (o_clk_cfg.pll_n == {1'h0, $past(i_req.wdata[3:0])}))
    else $error("pll ratio for plain code wrong");

  // The ratio never leaves 2..17, whatever was written
  AST_PLL_N_RANGE: assert property (
    (o_clk_cfg.pll_n >= 5'h02) &&
      (o_clk_cfg.pll_n <= N_VAL_17))
    else $error("pll ratio out of range");

  // Attack source flag follows the written top bit
  AST_ATK_OVR: assert property (
    wr_attack |=>
      (o_attack_override == $past(i_req.wdata[ATK_SEL_BIT])))
    else $error("attack source flag does not follow write");

  // Attack source flag holds while the register is not written
  AST_ATK_OVR_HOLD: assert property (
    !wr_attack |=>
      $stable(o_attack_override))
    else $error("attack source flag moved without write");

  // Override with baseline code 3 and multiplier 0 gives 11 ms
  AST_ATK_BASE_11: assert property (
    (wr_attack && i_req.wdata[7:2] == 6'h38) |=>
      (o_left_attack_ms == 11'h00B))
    else $error("largest baseline attack time wrong");

  // A local attack time stays between 7 ms and 11 ms times 128
  AST_ATK_RANGE: assert property (
    o_attack_override |->
      (o_left_attack_ms >= 11'h007 && o_left_attack_ms <= 11'h580))
    else $error("local attack time out of range");

  // Main scenarios
  COV_OVERRIDE_MAX: cover property (wr_attack && i_req.wdata[7:2] == 6'h3F);
  COV_SAME_CYCLE: cover property (i_req.wr && i_req.rd && hit_clk_gen);
  COV_PLAIN_CORE: cover property (wr_core_src && i_req.wdata[0]);
  COV_BCLK_BOTH: cover property (o_div_in_bclk && o_pll_ref_bclk);
  COV_RSVD_READ: cover property (i_req.rd && hit_rsvd_a);

endmodule : ccaa_regs

// File: bench/ccaa_tb.sv
// Self-checking testbench of the clock source and attack time bank
`timescale 1ns/1ns

module tb;
  import ccaa_pkg::*;

  logic                i_clk_sys;
  logic                i_rstn;
  ccaa_req_t           req;
  logic [ATK_MS_W-1:0] legacy;
  logic                rd_valid;
  logic [7:0]          rd_data;
  ccaa_clk_cfg_t       cfg;
  logic                div_bclk;
  logic                ref_bclk;
  logic                ovr;
  logic [ATK_MS_W-1:0] atk_ms;
  int                  err_total;
  int                  n_tests;
  int                  cyc = 0;

  ccaa_regs ccaa_regs_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_req(req), .i_legacy_attack_ms(legacy), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_clk_cfg(cfg), .o_div_in_bclk(div_bclk),
    .o_pll_ref_bclk(ref_bclk), .o_attack_override(ovr),
    .o_left_attack_ms(atk_ms));

  // Free-running system clock, 10 ns period
  initial begin
    i_clk_sys = 1'h0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input string nm, input logic [10:0] exp,
                     input logic [10:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; returns once the store edge has settled
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    req.wr    <= 1'h1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge i_clk_sys);
    req.wr    <= 1'h0;
    #1;
  endtask : wr_reg

  // One-cycle read strobe; answer one edge later, then the port idles
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    req.rd   <= 1'h1;
    req.addr <= a;
    @(posedge i_clk_sys);
    req.rd   <= 1'h0;
    #1;
    chk("rd_valid", 11'h001, {10'h000, rd_valid});
    chk("rd_data", {3'h0, exp}, {3'h0, rd_data});
    @(posedge i_clk_sys);
    #1;
    chk("rd_idle", 11'h000, {10'h000, rd_valid});
    chk("rd_zero", 11'h000, {3'h0, rd_data});
  endtask : rd_chk

  // Write and read in one cycle, then a back-to-back read of the new value
  task automatic t_overlap();
    @(posedge i_clk_sys);
    req.wr    <= 1'h1;
    req.rd    <= 1'h1;
    req.addr  <= ADDR_CLK_GEN;
    req.wdata <= 8'h8A;
    @(posedge i_clk_sys);
    req.wr <= 1'h0;
    #1;
    chk("rd_old", 11'h0AF, {3'h0, rd_data});
    chk("pll_n", 11'h00A, {6'h00, cfg.pll_n});
    chk("ref_bclk", 11'h000, {10'h000, ref_bclk});
    @(posedge i_clk_sys);
    req.rd <= 1'h0;
    #1;
    chk("rd_valid", 11'h001, {10'h000, rd_valid});
    chk("rd_new", 11'h08A, {3'h0, rd_data});
  endtask : t_overlap

  // Reset values of every slot and output but the two bit clock flags, plus an unmapped read
  task automatic t_reset();
    rd_chk(ADDR_RSVD_A, 8'h00);
    rd_chk(ADDR_CORE_SRC, 8'h00);
    rd_chk(ADDR_CLK_GEN, 8'h02);
    rd_chk(ADDR_ATTACK, 8'h00);
    rd_chk(8'h68, 8'h00);
    chk("pll_n", 11'h002, {6'h00, cfg.pll_n});
    chk("core_sel", 11'h000, {10'h000, cfg.core_sel});
    chk("div_in", 11'h000, {9'h000, cfg.div_in});
    chk("pll_ref", 11'h000, {9'h000, cfg.pll_ref});
    chk("override", 11'h000, {10'h000, ovr});
    chk("attack_ms", 11'h155, atk_ms);
  endtask : t_reset

  // Writes into read-only places must not stick
  task automatic t_rsvd();
    wr_reg(ADDR_RSVD_A, 8'hFF);
    rd_chk(ADDR_RSVD_A, 8'h00);
    wr_reg(ADDR_CORE_SRC, 8'hFF);
    chk("core_sel", 11'h001, {10'h000, cfg.core_sel});
    rd_chk(ADDR_CORE_SRC, 8'h01);
    wr_reg(ADDR_CORE_SRC, 8'h00);
    chk("core_sel", 11'h000, {10'h000, cfg.core_sel});
  endtask : t_rsvd

  // Every divider code, with both legal pin codes on each select
  task automatic t_clkgen();
    logic [1:0] dv;
    logic [1:0] rf;
    logic [4:0] nx;
    for (int n = 0; n < 16; n++) begin
      dv = n[0] ? SRC_BCLK : SRC_MCLK;
      rf = n[1] ? SRC_BCLK : SRC_MCLK;
      nx = (n == 0) ? 5'h10 : (n == 1) ? 5'h11 : 5'(n);
      wr_reg(ADDR_CLK_GEN, {dv, rf, 4'(n)});
      chk("pll_n", {6'h00, nx}, {6'h00, cfg.pll_n});
      chk("div_in", {9'h000, dv}, {9'h000, cfg.div_in});
      chk("div_bclk", {10'h000, n[0]}, {10'h000, div_bclk});
      chk("pll_ref", {9'h000, rf}, {9'h000, cfg.pll_ref});
      chk("ref_bclk", {10'h000, n[1]}, {10'h000, ref_bclk});
      rd_chk(ADDR_CLK_GEN, {dv, rf, 4'(n)});
    end
  endtask : t_clkgen

  // All baseline and multiplier codes, then back to the legacy source
  task automatic t_attack();
    logic [10:0] base [4];
    base = '{11'h007, 11'h008, 11'h00A, 11'h00B};
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        wr_reg(ADDR_ATTACK, {1'h1, 2'(b), 3'(m), 2'h0});
        @(posedge i_clk_sys);
        #1;
        chk("override", 11'h001, {10'h000, ovr});
        chk("attack_ms", base[b] << m, atk_ms);
      end
    end
    rd_chk(ADDR_ATTACK, 8'hFC);
    wr_reg(ADDR_ATTACK, 8'h7C);
    @(posedge i_clk_sys);
    legacy <= 11'h3A5;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("override", 11'h000, {10'h000, ovr});
    chk("attack_ms", 11'h3A5, atk_ms);
  endtask : t_attack

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_tests   = 0;
    i_rstn    = 1'h0;
    req       = '0;
    legacy    = 11'h155;
    repeat (16) @(posedge i_clk_sys);
    i_rstn <= 1'h1;
    @(posedge i_clk_sys);
    #1;
    t_reset();
    t_rsvd();
    t_clkgen();
    t_overlap();
    t_attack();
    wrap_up();
  end

endmodule : tb
